// ==== half_bridge_params.svh ====
// constants of the half-bridge serial control port
// assumes a 20 MHz system clock and a 16-bit frame
`ifndef HALF_BRIDGE_PARAMS_SVH
`define HALF_BRIDGE_PARAMS_SVH

`define WORD_BITS          16
`define SYNC_STAGES        2
`define CW_STATUS_CLEAR    0
`define CW_OPEN_LOAD_N     13
`define CW_SHORT_DELAY     14
`define CW_SOFT_ENABLE     15
`define CW_RESET_VALUE     16'hE000
`define STAGE_COUNT        6
`define STAGE_BASE_BIT     3
`define STAGE_STRIDE       4
`define ST_TEMP_PREWARN    0
`define ST_SHORT_CIRCUIT   13
`define ST_ENABLED         14
`define ST_SUPPLY_FAIL     15
`define MCLK_FREQ_MHZ      20
`define SC_DELAY_LONG_US   12000
`define SC_DELAY_SHORT_US  1500
`define SENSE_BITS         16

`endif

// ==== half_bridge_pkg.sv ====
// types shared by the half-bridge serial control port
// assumes half_bridge_params.svh supplies the widths
`include "half_bridge_params.svh"

package half_bridge_pkg;
    typedef logic [`WORD_BITS-1:0]   word_t;
    typedef logic [`STAGE_COUNT-1:0] stage_vec_t;
    typedef enum logic [0:0] {
        FRAME_IDLE   = 1'b0,
        FRAME_ACTIVE = 1'b1
    } frame_state_t;
endpackage

// ==== link_events_if.sv ====
// synchronised link edges and sensor levels passed from sampler to core
// assumes both ends run on mclk_i
`timescale 1ns/1ps
`include "half_bridge_params.svh"

interface link_events_if;
    logic                   cs_fall;
    logic                   cs_rise;
    logic                   clk_fall;
    logic                   clk_rise;
    logic                   din;
    logic [`SENSE_BITS-1:0] sense;

    modport sampler (output cs_fall, cs_rise, clk_fall, clk_rise, din, sense);
    modport core    (input  cs_fall, cs_rise, clk_fall, clk_rise, din, sense);
endinterface

// ==== link_sampler.sv ====
// brings the serial pins and sensor levels into the mclk_i domain
// assumes all inputs are asynchronous to mclk_i
`timescale 1ns/1ps
`include "half_bridge_params.svh"

module link_sampler (
    input  wire logic                   mclk_i,
    input  wire logic                   rst_b_i,
    input  wire logic                   frame_sel_b_i,
    input  wire logic                   serial_clk_i,
    input  wire logic                   serial_in_line_i,
    input  wire logic [`SENSE_BITS-1:0] sense_i,
    link_events_if.sampler              ev
);
    localparam int W = 3 + `SENSE_BITS;

    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [1:0]   prev;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_stable;
    logic [1:0]   next_prev;

    always_comb begin
        next_meta   = {sense_i, serial_in_line_i, serial_clk_i, frame_sel_b_i};
        next_stable = meta;
        next_prev   = stable[1:0];
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta   <= W'(1);
            stable <= W'(1);
            prev   <= 2'h1;
        end else begin
            meta   <= next_meta;
            stable <= next_stable;
            prev   <= next_prev;
        end
    end

    // edges are taken only from the second stage, never from meta
    assign ev.cs_fall  = prev[0] & ~stable[0];
    assign ev.cs_rise  = ~prev[0] & stable[0];
    assign ev.clk_fall = prev[1] & ~stable[1];
    assign ev.clk_rise = ~prev[1] & stable[1];
    assign ev.din      = stable[2];
    assign ev.sense    = stable[W-1:3];
endmodule

// ==== half_bridge_serial_control.sv ====
// serial control port of a triple half-bridge driver: control word in,
// status word out, stage switching with short-circuit shutdown timing
// assumes serial pins and sensor levels are asynchronous to mclk_i
`timescale 1ns/1ps
`include "half_bridge_params.svh"

module half_bridge_serial_control #(
    parameter int SC_LONG_CYCLES  = `SC_DELAY_LONG_US * `MCLK_FREQ_MHZ,
    parameter int SC_SHORT_CYCLES = `SC_DELAY_SHORT_US * `MCLK_FREQ_MHZ
) (
    input  wire logic                    mclk_i,
    input  wire logic                    rst_b_i,
    input  wire logic                    frame_sel_b_i,
    input  wire logic                    serial_clk_i,
    input  wire logic                    serial_in_line_i,
    input  wire logic                    hw_enable_i,
    input  wire logic                    temp_prewarn_i,
    input  wire logic                    over_temp_i,
    input  wire logic                    supply_uv_i,
    input  wire logic [`STAGE_COUNT-1:0] over_current_i,
    input  wire logic [`STAGE_COUNT-1:0] open_load_i,
    output logic                         serial_out_o,
    output logic                         serial_out_oe_b_o,
    output logic [`STAGE_COUNT-1:0]      stage_on_o,
    output logic                         open_load_en_o,
    output logic                         long_delay_o,
    output logic                         standby_o
);
    localparam int CW = $clog2(SC_LONG_CYCLES + 1);

    link_events_if ev ();

    link_sampler u_sampler (
        .mclk_i          (mclk_i),
        .rst_b_i         (rst_b_i),
        .frame_sel_b_i   (frame_sel_b_i),
        .serial_clk_i    (serial_clk_i),
        .serial_in_line_i(serial_in_line_i),
        .sense_i         ({open_load_i, over_current_i, supply_uv_i,
                           over_temp_i, temp_prewarn_i, hw_enable_i}),
        .ev              (ev.sampler)
    );

    logic                            hw_en_s;
    logic                            prewarn_s;
    logic                            ot_s;
    logic                            uv_s;
    half_bridge_pkg::stage_vec_t     oc_s;
    half_bridge_pkg::stage_vec_t     ol_s;

    assign hw_en_s   = ev.sense[0];
    assign prewarn_s = ev.sense[1];
    assign ot_s      = ev.sense[2];
    assign uv_s      = ev.sense[3];
    assign oc_s      = ev.sense[9:4];
    assign ol_s      = ev.sense[15:10];

    half_bridge_pkg::frame_state_t   state;
    half_bridge_pkg::frame_state_t   next_state;
    half_bridge_pkg::word_t          rx_shift;
    half_bridge_pkg::word_t          next_rx_shift;
    half_bridge_pkg::word_t          tx_shift;
    half_bridge_pkg::word_t          next_tx_shift;
    half_bridge_pkg::word_t          control_word;
    half_bridge_pkg::word_t          next_control_word;
    half_bridge_pkg::word_t          status_word;
    logic                            seen_fall;
    logic                            next_seen_fall;
    logic                            next_serial_out;
    logic                            next_serial_out_oe_b;
    logic                            short_circuit_flag;
    logic                            next_short_circuit_flag;
    logic                            supply_fail_flag;
    logic                            next_supply_fail_flag;
    logic                            over_temp_flag;
    logic                            next_over_temp_flag;
    logic                            next_open_load_en;
    logic                            next_long_delay;
    logic                            next_standby;
    half_bridge_pkg::stage_vec_t     next_stage_on;
    half_bridge_pkg::stage_vec_t     tripped;
    half_bridge_pkg::stage_vec_t     trip_evt;
    half_bridge_pkg::stage_vec_t     stage_req;
    logic                            apply;
    logic                            status_clear;
    logic                            enabled;
    logic [CW-1:0]                   sc_limit;

    // a frame is applied only when it was opened by a select fall
    assign apply        = ev.cs_rise && (state == half_bridge_pkg::FRAME_ACTIVE);
    assign status_clear = apply && rx_shift[`CW_STATUS_CLEAR];
    assign enabled      = hw_en_s & control_word[`CW_SOFT_ENABLE];
    assign sc_limit     = control_word[`CW_SHORT_DELAY] ? CW'(SC_LONG_CYCLES)
                                                        : CW'(SC_SHORT_CYCLES);

    always_comb begin
        status_word                    = '0;
        status_word[`ST_TEMP_PREWARN]  = prewarn_s;
        for (int k = 0; k < `STAGE_COUNT; k++) begin
            stage_req[k] = control_word[`STAGE_BASE_BIT + `STAGE_STRIDE * (k / 2) + (k % 2)];
            status_word[`STAGE_BASE_BIT + `STAGE_STRIDE * (k / 2) + (k % 2)] =
                control_word[`CW_OPEN_LOAD_N] ? stage_on_o[k] : ol_s[k];
        end
        status_word[`ST_SHORT_CIRCUIT] = short_circuit_flag;
        status_word[`ST_ENABLED]       = enabled;
        status_word[`ST_SUPPLY_FAIL]   = supply_fail_flag;
        if (over_temp_flag) begin
            status_word = '1;
        end
    end

    // frame engine; it ignores the enables so standby keeps the port alive
    always_comb begin
        next_state           = state;
        next_rx_shift        = rx_shift;
        next_tx_shift        = tx_shift;
        next_control_word    = control_word;
        next_seen_fall       = seen_fall;
        next_serial_out      = serial_out_o;
        next_serial_out_oe_b = serial_out_oe_b_o;
        case (state)
            half_bridge_pkg::FRAME_IDLE: begin
                next_serial_out_oe_b = 1'b1;
                if (ev.cs_fall) begin
                    next_state           = half_bridge_pkg::FRAME_ACTIVE;
                    next_tx_shift        = status_word >> 1;
                    next_serial_out      = status_word[0];
                    next_serial_out_oe_b = 1'b0;
                    next_seen_fall       = 1'b0;
                end
            end
            half_bridge_pkg::FRAME_ACTIVE: begin
                if (ev.cs_rise) begin
                    next_state           = half_bridge_pkg::FRAME_IDLE;
                    next_serial_out_oe_b = 1'b1;
                    next_control_word    = rx_shift;
                end else if (ev.clk_fall) begin
                    next_rx_shift  = {ev.din, rx_shift[`WORD_BITS-1:1]};
                    next_seen_fall = 1'b1;
                end else if (ev.clk_rise && seen_fall) begin
                    // the first rise only opens the bit cell of bit zero
                    next_serial_out = tx_shift[0];
                    next_tx_shift   = tx_shift >> 1;
                end
            end
            default: begin
                next_state           = half_bridge_pkg::FRAME_IDLE;
                next_serial_out_oe_b = 1'b1;
            end
        endcase
    end

    // hardware sets win over the clear carried by the same frame
    always_comb begin
        next_short_circuit_flag = (|trip_evt) | (short_circuit_flag & ~status_clear);
        next_supply_fail_flag   = uv_s | (supply_fail_flag & ~status_clear);
        next_over_temp_flag     = ot_s | (over_temp_flag & ~status_clear);
        next_stage_on = stage_req & ~tripped & {`STAGE_COUNT{enabled & ~over_temp_flag}};
        next_open_load_en       = ~control_word[`CW_OPEN_LOAD_N];
        next_long_delay         = control_word[`CW_SHORT_DELAY];
        next_standby            = ~enabled;
    end

    for (genvar k = 0; k < `STAGE_COUNT; k++) begin : g_stage
        logic [CW-1:0] sc_count;
        logic [CW-1:0] next_sc_count;
        logic          next_tripped;

        // a stage that stays in over-current for the selected delay is latched off
        always_comb begin
            trip_evt[k]   = 1'b0;
            next_sc_count = '0;
            if (stage_on_o[k] && oc_s[k]) begin
                if (sc_count >= sc_limit - CW'(1)) begin
                    trip_evt[k] = 1'b1;
                end else begin
                    next_sc_count = sc_count + CW'(1);
                end
            end
            next_tripped = trip_evt[k] | (tripped[k] & ~status_clear);
        end

        always_ff @(posedge mclk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                sc_count   <= '0;
                tripped[k] <= 1'b0;
            end else begin
                sc_count   <= next_sc_count;
                tripped[k] <= next_tripped;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state              <= half_bridge_pkg::FRAME_IDLE;
            rx_shift           <= '0;
            tx_shift           <= '0;
            control_word       <= `CW_RESET_VALUE;
            seen_fall          <= 1'b0;
            serial_out_o       <= 1'b0;
            serial_out_oe_b_o  <= 1'b1;
            short_circuit_flag <= 1'b0;
            supply_fail_flag   <= 1'b0;
            over_temp_flag     <= 1'b0;
            stage_on_o         <= '0;
            open_load_en_o     <= 1'b0;
            long_delay_o       <= 1'b1;
            standby_o          <= 1'b1;
        end else begin
            state              <= next_state;
            rx_shift           <= next_rx_shift;
            tx_shift           <= next_tx_shift;
            control_word       <= next_control_word;
            seen_fall          <= next_seen_fall;
            serial_out_o       <= next_serial_out;
            serial_out_oe_b_o  <= next_serial_out_oe_b;
            short_circuit_flag <= next_short_circuit_flag;
            supply_fail_flag   <= next_supply_fail_flag;
            over_temp_flag     <= next_over_temp_flag;
            stage_on_o         <= next_stage_on;
            open_load_en_o     <= next_open_load_en;
            long_delay_o       <= next_long_delay;
            standby_o          <= next_standby;
        end
    end
endmodule

// ==== half_bridge_serial_control_asserts.sv ====
// concurrent checks on the ports of the half-bridge serial control port
// assumes mclk_i samples every pin and rst_b_i is the only reset
`timescale 1ns/1ps
`include "half_bridge_params.svh"
module half_bridge_serial_control_asserts #(
    parameter int SC_LONG_CYCLES  = 240000,
    parameter int SC_SHORT_CYCLES = 30000
) (
    input wire logic                    mclk_i,
    input wire logic                    rst_b_i,
    input wire logic                    frame_sel_b_i,
    input wire logic                    serial_clk_i,
    input wire logic                    serial_in_line_i,
    input wire logic                    hw_enable_i,
    input wire logic                    temp_prewarn_i,
    input wire logic                    over_temp_i,
    input wire logic                    supply_uv_i,
    input wire logic [`STAGE_COUNT-1:0] over_current_i,
    input wire logic [`STAGE_COUNT-1:0] open_load_i,
    input wire logic                    serial_out_o,
    input wire logic                    serial_out_oe_b_o,
    input wire logic [`STAGE_COUNT-1:0] stage_on_o,
    input wire logic                    open_load_en_o,
    input wire logic                    long_delay_o,
    input wire logic                    standby_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    int since_edge;
    int since_rise;
    int oc_run;
    // since_edge and since_rise saturate at 99 so a long idle spell cannot wrap into a false pass; oc_run does not saturate
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            since_edge <= 99;
            since_rise <= 99;
            oc_run     <= 0;
        end else begin
            since_edge <= ($rose(serial_clk_i) || $fell(frame_sel_b_i)) ? 0 :
                          (since_edge < 99 ? since_edge + 1 : 99);
            since_rise <= $rose(frame_sel_b_i) ? 0 : (since_rise < 99 ? since_rise + 1 : 99);
            oc_run     <= (|(stage_on_o & over_current_i)) ? oc_run + 1 : 0;
        end
    end
    a_oe_timely: assert property ($fell(frame_sel_b_i) |-> ##[1:4] !serial_out_oe_b_o)
        else $error("data out not driven after select fall");
    a_oe_release: assert property (frame_sel_b_i [*5] |-> serial_out_oe_b_o)
        else $error("data out driven while deselected");
    a_out_step: assert property (!serial_out_oe_b_o && $changed(serial_out_o) |-> since_edge <= 6)
        else $error("data out changed away from a rising serial clock");
    a_apply_rise: assert property ($changed(open_load_en_o) || $changed(long_delay_o)
        |-> frame_sel_b_i && since_rise <= 7)
        else $error("control outputs changed outside frame end");
    a_stage_hold: assert property (!frame_sel_b_i [*8] ##0 (over_current_i == '0 && !over_temp_i
        && hw_enable_i) |-> $stable(stage_on_o))
        else $error("stage outputs changed inside a frame");
    a_standby_hw: assert property (!hw_enable_i [*6] |-> standby_o)
        else $error("standby not entered with enable pin low");
    a_stages_off: assert property (standby_o [*2] |-> stage_on_o == '0)
        else $error("stage on during standby");
    a_temp_off: assert property (over_temp_i [*6] |-> stage_on_o == '0)
        else $error("stage on during over-temperature");
    a_trip_bound: assert property (oc_run <= (long_delay_o ? SC_LONG_CYCLES : SC_SHORT_CYCLES) + 8)
        else $error("over-current persisted past the shutdown delay");
endmodule
bind half_bridge_serial_control half_bridge_serial_control_asserts #(
    .SC_LONG_CYCLES(SC_LONG_CYCLES), .SC_SHORT_CYCLES(SC_SHORT_CYCLES)) chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .frame_sel_b_i(frame_sel_b_i),
    .serial_clk_i(serial_clk_i), .serial_in_line_i(serial_in_line_i),
    .hw_enable_i(hw_enable_i), .temp_prewarn_i(temp_prewarn_i), .over_temp_i(over_temp_i),
    .supply_uv_i(supply_uv_i), .over_current_i(over_current_i), .open_load_i(open_load_i),
    .serial_out_o(serial_out_o), .serial_out_oe_b_o(serial_out_oe_b_o),
    .stage_on_o(stage_on_o), .open_load_en_o(open_load_en_o),
    .long_delay_o(long_delay_o), .standby_o(standby_o));

// ==== serial_master_model.sv ====
// behavioural controller that runs frames on the serial link
// assumes a 400 ns serial clock; the data-in line is driven low between frames
`timescale 1ns/1ps
module serial_master_model (
    output logic      frame_sel_b_o,
    output logic      serial_clk_o,
    output logic      serial_in_line_o,
    input  wire logic serial_data_i
);
    initial begin
        frame_sel_b_o    = 1'b1;
        serial_clk_o     = 1'b0;
        serial_in_line_o = 1'b0;
    end
    // clock stands low between frames; returned bits are read just before each fall
    task automatic xfer(input logic [16:0] w, input int nbits, output logic [15:0] rd);
        rd = '0;
        frame_sel_b_o = 1'b0;
        #200;
        for (int i = 0; i < nbits; i++) begin
            serial_clk_o     = 1'b1;
            serial_in_line_o = w[i];
            #200;
            if (i < 16) rd[i] = serial_data_i;
            serial_clk_o = 1'b0;
            #200;
        end
        serial_in_line_o = 1'b0;
        frame_sel_b_o    = 1'b1;
        #400;
    endtask
endmodule

// ==== test_half_bridge_serial_control.sv ====
// self-checking bench for the half-bridge serial control port
// assumes the model drives the link and the bench drives sensors
`timescale 1ns/1ps
`include "half_bridge_params.svh"
module test_half_bridge_serial_control;
    logic                    mclk_i         = 1'b0;
    logic                    rst_b_i        = 1'b0;
    logic                    hw_enable_i    = 1'b1;
    logic                    temp_prewarn_i = 1'b0;
    logic                    over_temp_i    = 1'b0;
    logic                    supply_uv_i    = 1'b0;
    logic [`STAGE_COUNT-1:0] over_current_i = '0;
    logic [`STAGE_COUNT-1:0] open_load_i    = '0;
    wire                     frame_sel_b_i, serial_clk_i, serial_in_line_i;
    wire                     serial_out_o, serial_out_oe_b_o;
    wire [`STAGE_COUNT-1:0]  stage_on_o;
    wire                     open_load_en_o, long_delay_o, standby_o;
    wire                     do_line = serial_out_oe_b_o ? 1'bz : serial_out_o;
    int                      n_errors = 0;
    int                      samples_checked = 0;

    always #25 mclk_i = ~mclk_i;

    half_bridge_serial_control #(.SC_LONG_CYCLES(40), .SC_SHORT_CYCLES(10)) uut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .frame_sel_b_i(frame_sel_b_i),
        .serial_clk_i(serial_clk_i), .serial_in_line_i(serial_in_line_i),
        .hw_enable_i(hw_enable_i), .temp_prewarn_i(temp_prewarn_i), .over_temp_i(over_temp_i),
        .supply_uv_i(supply_uv_i), .over_current_i(over_current_i), .open_load_i(open_load_i),
        .serial_out_o(serial_out_o), .serial_out_oe_b_o(serial_out_oe_b_o),
        .stage_on_o(stage_on_o), .open_load_en_o(open_load_en_o),
        .long_delay_o(long_delay_o), .standby_o(standby_o));
    serial_master_model mdl (.frame_sel_b_o(frame_sel_b_i), .serial_clk_o(serial_clk_i),
        .serial_in_line_o(serial_in_line_i), .serial_data_i(do_line));

    function automatic half_bridge_pkg::word_t stage_bits(input logic [5:0] s);
        half_bridge_pkg::word_t w;
        w = '0;
        for (int k = 0; k < 6; k++) w[3 + 4 * (k / 2) + (k % 2)] = s[k];
        return w;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #7;
    endtask
    task automatic frame(input half_bridge_pkg::word_t w, output half_bridge_pkg::word_t rd);
        mdl.xfer({1'b0, w}, 16, rd);
        wait_cyc(8);
        chk("oe_b", 16'h1, {15'h0, serial_out_oe_b_o});
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic t_reset;
        chk("oe_b", 16'h1, {15'h0, serial_out_oe_b_o});
        chk("open_load_en", 16'h0, {15'h0, open_load_en_o});
        chk("long_delay", 16'h1, {15'h0, long_delay_o});
        chk("standby", 16'h0, {15'h0, standby_o});
        chk("stage_on", 16'h0, {10'h0, stage_on_o});
    endtask
    task automatic t_stages;
        half_bridge_pkg::word_t rd, prev;
        prev = 16'hE000;
        for (int k = 0; k < 7; k++) begin
            frame(16'hE000 | (k < 6 ? stage_bits(6'h01 << k) : 16'h0), rd);
            chk("status", (prev & 16'h1998) | 16'h4000, rd);
            chk("stage_on", k < 6 ? 16'h1 << k : 16'h0, {10'h0, stage_on_o});
            prev = 16'hE000 | (k < 6 ? stage_bits(6'h01 << k) : 16'h0);
        end
    endtask
    task automatic t_modes;
        half_bridge_pkg::word_t w, rd, prev;
        open_load_i = 6'h2D;
        prev = 16'hE000;
        for (int m = 0; m < 9; m++) begin
            w = (m == 8) ? 16'hE000 : half_bridge_pkg::word_t'(m) << 13;
            frame(w, rd);
            chk("status", (prev[13] ? 16'h0 : stage_bits(6'h2D)) | {1'b0, prev[15], 14'h0}, rd);
            chk("open_load_en", {15'h0, ~w[13]}, {15'h0, open_load_en_o});
            chk("long_delay", {15'h0, w[14]}, {15'h0, long_delay_o});
            chk("standby", {15'h0, ~w[15]}, {15'h0, standby_o});
            prev = w;
        end
        open_load_i = 6'h00;
    endtask
    task automatic t_flags;
        half_bridge_pkg::word_t rd;
        temp_prewarn_i = 1'b1;
        supply_uv_i = 1'b1;
        wait_cyc(6);
        supply_uv_i = 1'b0;
        frame(16'hE000, rd);
        chk("status", 16'hC001, rd);
        over_temp_i = 1'b1;
        wait_cyc(6);
        over_temp_i = 1'b0;
        frame(16'hE000 | stage_bits(6'h15), rd);
        chk("status", 16'hFFFF, rd);
        chk("stage_on", 16'h0, {10'h0, stage_on_o});
        frame(16'hE001, rd);
        chk("status", 16'hFFFF, rd);
        frame(16'hE000, rd);
        chk("status", 16'h4001, rd);
        temp_prewarn_i = 1'b0;
    endtask
    task automatic t_short;
        half_bridge_pkg::word_t rd;
        frame(16'hA008, rd);
        chk("stage_on", 16'h1, {10'h0, stage_on_o});
        over_current_i = 6'h01;
        wait_cyc(30);
        chk("stage_on", 16'h0, {10'h0, stage_on_o});
        over_current_i = 6'h00;
        frame(16'hE009, rd);
        chk("status", 16'h6000, rd);
        over_current_i = 6'h01;
        wait_cyc(30);
        chk("stage_on", 16'h1, {10'h0, stage_on_o});
        over_current_i = 6'h00;
        frame(16'hE000, rd);
    endtask
    task automatic t_hwen;
        half_bridge_pkg::word_t rd;
        frame(16'hE000 | stage_bits(6'h15), rd);
        hw_enable_i = 1'b0;
        wait_cyc(8);
        chk("standby", 16'h1, {15'h0, standby_o});
        chk("stage_on", 16'h0, {10'h0, stage_on_o});
        frame(16'hE000 | stage_bits(6'h15), rd);
        chk("status", 16'h0, rd);
        hw_enable_i = 1'b1;
        wait_cyc(8);
        chk("stage_on", 16'h15, {10'h0, stage_on_o});
    endtask
    task automatic t_long;
        half_bridge_pkg::word_t rd;
        mdl.xfer({16'hE000 | stage_bits(6'h02), 1'b1}, 17, rd);
        wait_cyc(8);
        chk("status", 16'h4000 | stage_bits(6'h15), rd);
        chk("stage_on", 16'h2, {10'h0, stage_on_o});
    endtask

    initial begin
        repeat (2) @(posedge mclk_i);
        #7;
        rst_b_i = 1'b1;
        wait_cyc(4);
        t_reset;
        t_stages;
        t_modes;
        t_flags;
        t_short;
        t_hwen;
        t_long;
        wrap_up;
    end
    // 26 frames of about 7.4 us each; the limit leaves ample margin
    initial begin
        #2000000;
        n_errors++;
        wrap_up;
    end
endmodule
